// ===== include/rsa_pkg.sv
// Shared constants and types for the serial register access link
`default_nettype none
package rsa_pkg;
  // ------------------------------------------------------------
  // Slave address
  // ------------------------------------------------------------
  localparam logic [3:0] DEV_ID = 4'hd;
  localparam logic [2:0] DEV_SEL = 3'h7;
  // ------------------------------------------------------------
  // Register space and page layout
  // ------------------------------------------------------------
  localparam int unsigned REG_WORDS_DEF = 64;
  localparam int unsigned PAGE_BITS = 3;
  localparam int unsigned PAGE_BYTES = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WC_TIME_MS = 5;
  localparam int unsigned WC_CYCLES = WC_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOST_QTR_CYCLES = 8;
  // ------------------------------------------------------------
  // States and commands
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_DEV = 3'b001,
    DS_AHI = 3'b010,
    DS_ALO = 3'b011,
    DS_WDAT = 3'b100,
    DS_RDAT = 3'b101
  } rsa_dev_st_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BITS = 2'b10,
    HS_STOP = 2'b11
  } rsa_host_st_e;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_STOP = 2'b11
  } rsa_op_e;
endpackage : rsa_pkg
`default_nettype wire

// ===== include/rsa_if.sv
// Two-wire link between the bus master end and the register slave end
`timescale 1ns/100ps
`default_nettype none
interface rsa_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // ------------------------------------------------------------
  // Open-drain wired levels, pulled up when nobody drives
  // ------------------------------------------------------------
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
  modport dev (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe
  );
  modport host (
    input scl,
    input sda,
    output scl_o,
    output scl_oe,
    output sda_h_o,
    output sda_h_oe
  );
endinterface : rsa_if
`default_nettype wire

// ===== design/rsa_line_sync.sv
// Pin synchroniser with clock edge and start/stop detection
`timescale 1ns/100ps
`default_nettype none
module rsa_line_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_s_ff,
  output logic scl_rise_ff,
  output logic scl_fall_ff,
  output logic start_ff,
  output logic stop_ff
);
  logic scl_m_ff;
  logic scl_s_ff;
  logic sda_m_ff;
  logic sda_q_ff;
  logic scl_d_ff;
  // ------------------------------------------------------------
  // Two-stage capture, lines idle high
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_i;
      sda_q_ff <= sda_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_s_ff <= sda_q_ff;
    end
  end
  // ------------------------------------------------------------
  // Events, one cycle pulses
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_rise_ff <= 1'b0;
      scl_fall_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      scl_rise_ff <= scl_s_ff & ~scl_d_ff;
      scl_fall_ff <= ~scl_s_ff & scl_d_ff;
      start_ff <= scl_s_ff & scl_d_ff & sda_s_ff & ~sda_q_ff;
      stop_ff <= scl_s_ff & scl_d_ff & ~sda_s_ff & sda_q_ff;
    end
  end
endmodule : rsa_line_sync
`default_nettype wire

// ===== design/rsa_dev.sv
// Register slave end of the two-wire link
// Notes on behaviour
// - Byte write: address, two register bytes, data.
// - Write enable comes from the write_enable_latch input.
// - Busy after write stop, bus ignored, released.
// - Page write takes up to seven more bytes.
// - Page write acks, increments, wraps inside page.
// - Extra page bytes overwrite earlier ones.
// - Stop mid-byte or before data aborts write.
// - No address ack until write cycle ends.
// - Counter holds last read address plus one.
// - Read address acked, then eight data bits.
// - Master ends read with no ack, stop.
// - Random read: dummy write, repeated start, read.
// - Stop after register address sets counter only.
// - Sequential read increments, wraps register space.
// - Upper address nibble must be 1101.
// - Select bits three to one are 111.
// - Address bit zero selects read or write.
// - Ack only when seven bits match 1101111.
// - Write transfers carry two register address bytes.
// - Same slave address in both read phases.
// - Nothing answered before a start is seen.
// - Data bytes refused while write enable clear.
// - Read stops when master gives no ack.
`timescale 1ns/100ps
`default_nettype none
module rsa_dev #(
  parameter int unsigned REG_WORDS = rsa_pkg::REG_WORDS_DEF,
  parameter int unsigned WC_CYCLES = rsa_pkg::WC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  rsa_if.dev bus,
  input wire logic write_enable_latch,
  input wire logic [$clog2(REG_WORDS)-1:0] user_addr,
  output logic [7:0] user_data_ff,
  output logic busy_ff
);
  import rsa_pkg::*;
  localparam int unsigned AW = $clog2(REG_WORDS);
  localparam int unsigned CW = $clog2(WC_CYCLES + 1);
  localparam logic [CW-1:0] WC_LAST = CW'(WC_CYCLES - 1);

  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_p;
  logic stop_p;
  rsa_dev_st_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic ack_ph_ff;
  logic mack_ff;
  logic rw_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] addr_hi_ff;
  logic [AW-1:0] addr_ff;
  logic [PAGE_BYTES-1:0] mask_ff;
  logic [7:0] page_ff [PAGE_BYTES];
  logic wr_go_ff;
  logic [CW-1:0] wc_cnt_ff;
  logic [7:0] mem [REG_WORDS];
  logic [15:0] addr_full;
  logic addr_match;
  logic rd_next;

  assign addr_full = {addr_hi_ff, shift_ff};
  assign addr_match = (shift_ff[7:1] == {DEV_ID, DEV_SEL});
  assign rd_next = (state_ff == DS_DEV && rw_ff) || (state_ff == DS_RDAT && !mack_ff);

  rsa_line_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .sda_s_ff(sda_s),
    .scl_rise_ff(scl_rise),
    .scl_fall_ff(scl_fall),
    .start_ff(start_p),
    .stop_ff(stop_p)
  );

  // ------------------------------------------------------------
  // Bus protocol engine
  // ------------------------------------------------------------
  // Pulls sda low only; sda_d_o is held low so the enable alone
  // decides the wire.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= DS_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ph_ff <= 1'b0;
      mack_ff <= 1'b1;
      rw_ff <= 1'b0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      addr_ff <= '0;
      mask_ff <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_ff[i] <= REG_RESET;
      end
      wr_go_ff <= 1'b0;
      bus.sda_d_oe <= 1'b0;
      bus.sda_d_o <= 1'b0;
    end else begin
      wr_go_ff <= 1'b0;
      if (start_p) begin
        // Start also acts as repeated start in a random read
        state_ff <= DS_DEV;
        bit_cnt_ff <= 4'h0;
        ack_ph_ff <= 1'b0;
        bus.sda_d_oe <= 1'b0;
        if (!busy_ff) begin
          mask_ff <= '0;
        end
      end else if (stop_p) begin
        state_ff <= DS_IDLE;
        bit_cnt_ff <= 4'h0;
        ack_ph_ff <= 1'b0;
        bus.sda_d_oe <= 1'b0;
        // Only a stop on a byte boundary after an acked data byte commits;
        // the stop's own clock rise has already counted one bit.
        if (state_ff == DS_WDAT && bit_cnt_ff == 4'h1 && !ack_ph_ff && mask_ff != '0) begin
          wr_go_ff <= 1'b1;
        end
      end else if (state_ff == DS_IDLE) begin
        bus.sda_d_oe <= 1'b0;
      end else if (scl_rise) begin
        if (ack_ph_ff) begin
          mack_ff <= sda_s;
        end else if (bit_cnt_ff != BYTE_BITS) begin
          shift_ff <= {shift_ff[6:0], sda_s};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_ph_ff) begin
          ack_ph_ff <= 1'b0;
          bit_cnt_ff <= 4'h0;
          bus.sda_d_oe <= 1'b0;
          if (rd_next) begin
            tx_ff <= {mem[addr_ff][6:0], 1'b0};
            bus.sda_d_oe <= ~mem[addr_ff][7];
            addr_ff <= addr_ff + AW'(1);
            state_ff <= DS_RDAT;
          end else if (state_ff == DS_RDAT) begin
            state_ff <= DS_IDLE;
          end else if (state_ff == DS_DEV) begin
            state_ff <= DS_AHI;
          end else if (state_ff == DS_AHI) begin
            state_ff <= DS_ALO;
          end else begin
            state_ff <= DS_WDAT;
          end
        end else if (bit_cnt_ff == BYTE_BITS) begin
          ack_ph_ff <= 1'b1;
          bus.sda_d_oe <= 1'b1;
          case (state_ff)
            DS_DEV: begin
              rw_ff <= shift_ff[0];
              if (!addr_match || busy_ff) begin
                state_ff <= DS_IDLE;
                ack_ph_ff <= 1'b0;
                bus.sda_d_oe <= 1'b0;
              end
            end
            DS_AHI: begin
              addr_hi_ff <= shift_ff;
            end
            DS_ALO: begin
              addr_ff <= addr_full[AW-1:0];
            end
            DS_WDAT: begin
              if (write_enable_latch) begin
                // Later bytes of a long page land on earlier slots
                page_ff[addr_ff[PAGE_BITS-1:0]] <= shift_ff;
                mask_ff[addr_ff[PAGE_BITS-1:0]] <= 1'b1;
                addr_ff <= {addr_ff[AW-1:PAGE_BITS],
                            addr_ff[PAGE_BITS-1:0] + PAGE_BITS'(1)};
              end else begin
                state_ff <= DS_IDLE;
                ack_ph_ff <= 1'b0;
                bus.sda_d_oe <= 1'b0;
              end
            end
            DS_RDAT: begin
              bus.sda_d_oe <= 1'b0;
            end
            default: begin
              state_ff <= DS_IDLE;
              ack_ph_ff <= 1'b0;
              bus.sda_d_oe <= 1'b0;
            end
          endcase
        end else if (state_ff == DS_RDAT) begin
          bus.sda_d_oe <= ~tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Nonvolatile write cycle
  // ------------------------------------------------------------
  // Loaded page bytes land at once so an aborted load never half-writes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      wc_cnt_ff <= '0;
      for (int i = 0; i < REG_WORDS; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (wr_go_ff) begin
      busy_ff <= 1'b1;
      wc_cnt_ff <= WC_LAST;
    end else if (busy_ff) begin
      if (wc_cnt_ff == '0) begin
        busy_ff <= 1'b0;
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (mask_ff[i]) begin
            mem[{addr_ff[AW-1:PAGE_BITS], PAGE_BITS'(i)}] <= page_ff[i];
          end
        end
      end else begin
        wc_cnt_ff <= wc_cnt_ff - CW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Local read port
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_data_ff <= REG_RESET;
    end else begin
      user_data_ff <= mem[user_addr];
    end
  end
endmodule : rsa_dev
`default_nettype wire

// ===== design/rsa_host.sv
// Bus master end of the two-wire link, one bus condition per command
`timescale 1ns/100ps
`default_nettype none
module rsa_host #(
  parameter int unsigned QTR_CYCLES = rsa_pkg::HOST_QTR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  rsa_if.host bus,
  input wire logic cmd_valid,
  input wire rsa_pkg::rsa_op_e cmd_op,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_nack,
  output logic cmd_ready_ff,
  output logic rsp_valid_ff,
  output logic [7:0] rsp_rdata_ff,
  output logic rsp_ack_ff
);
  import rsa_pkg::*;
  localparam int unsigned QW = $clog2(QTR_CYCLES + 1);
  localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYCLES - 1);

  logic sda_s;
  logic tick_ff;
  logic [QW-1:0] div_ff;
  rsa_host_st_e state_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic [8:0] tx_ff;
  logic [8:0] rx_ff;

  rsa_line_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .sda_s_ff(sda_s),
    .scl_rise_ff(),
    .scl_fall_ff(),
    .start_ff(),
    .stop_ff()
  );

  // ------------------------------------------------------------
  // Quarter bit enable
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == '0);
      div_ff <= (div_ff == '0) ? QTR_LAST : div_ff - QW'(1);
    end
  end

  // ------------------------------------------------------------
  // Condition sequencer
  // ------------------------------------------------------------
  // Slow quarters leave room for the two-flop sampling on both ends.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= HS_IDLE;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      tx_ff <= 9'h1ff;
      rx_ff <= 9'h000;
      cmd_ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
      rsp_ack_ff <= 1'b0;
      bus.scl_o <= 1'b0;
      bus.scl_oe <= 1'b0;
      bus.sda_h_o <= 1'b0;
      bus.sda_h_oe <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (state_ff == HS_IDLE) begin
        if (cmd_valid && cmd_ready_ff) begin
          cmd_ready_ff <= 1'b0;
          q_ff <= 2'h0;
          bit_ff <= 4'h0;
          case (cmd_op)
            OP_START: state_ff <= HS_START;
            OP_STOP: state_ff <= HS_STOP;
            // Master ack slot: low to ask for more, high to end a read
            OP_READ: begin
              tx_ff <= {8'hff, cmd_nack};
              state_ff <= HS_BITS;
            end
            default: begin
              tx_ff <= {cmd_wdata, 1'b1};
              state_ff <= HS_BITS;
            end
          endcase
        end
      end else if (tick_ff) begin
        q_ff <= q_ff + 2'h1;
        case (state_ff)
          HS_START: begin
            case (q_ff)
              2'h0: bus.sda_h_oe <= 1'b0;
              2'h1: bus.scl_oe <= 1'b0;
              2'h2: bus.sda_h_oe <= 1'b1;
              default: begin
                bus.scl_oe <= 1'b1;
                state_ff <= HS_IDLE;
                cmd_ready_ff <= 1'b1;
                rsp_valid_ff <= 1'b1;
              end
            endcase
          end
          HS_BITS: begin
            case (q_ff)
              2'h0: bus.sda_h_oe <= ~tx_ff[8];
              2'h1: bus.scl_oe <= 1'b0;
              2'h2: rx_ff <= {rx_ff[7:0], sda_s};
              default: begin
                bus.scl_oe <= 1'b1;
                tx_ff <= {tx_ff[7:0], 1'b1};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == BYTE_BITS) begin
                  state_ff <= HS_IDLE;
                  cmd_ready_ff <= 1'b1;
                  rsp_valid_ff <= 1'b1;
                  rsp_rdata_ff <= rx_ff[8:1];
                  rsp_ack_ff <= ~rx_ff[0];
                end
              end
            endcase
          end
          HS_STOP: begin
            case (q_ff)
              2'h0: bus.sda_h_oe <= 1'b1;
              2'h1: bus.scl_oe <= 1'b0;
              2'h2: begin
                bus.sda_h_oe <= 1'b0;
                state_ff <= HS_IDLE;
                cmd_ready_ff <= 1'b1;
                rsp_valid_ff <= 1'b1;
              end
              default: state_ff <= HS_IDLE;
            endcase
          end
          default: state_ff <= HS_IDLE;
        endcase
      end
    end
  end
endmodule : rsa_host
`default_nettype wire

// ===== test/rsa_asserts.sv
// Slave drive rules checked on the two-wire link
`timescale 1ns/100ps
`default_nettype none
module rsa_asserts #(
  parameter int unsigned WC_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe
);
  logic scl_q_ff, sda_q_ff, seen_ff, rd_ff, adr_ok_ff, quiet_ff, lastack_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] sh_ff;
  int unsigned busy_cnt_ff;
  logic rise, start, stop;
  assign rise = scl & ~scl_q_ff;
  assign start = scl & scl_q_ff & sda_q_ff & ~sda;
  assign stop = scl & scl_q_ff & ~sda_q_ff & sda;
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_ff <= 1'h1;
      sda_q_ff <= 1'h1;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
    end
  end
  // Stop clock rise also counts, so commit needs exactly one rise after the ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ff <= 1'h0;
    end else if (start) begin
      seen_ff <= 1'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bit_ff, byte_ff, rd_ff, adr_ok_ff, quiet_ff, lastack_ff, sh_ff} <= '0;
    end else if (start) begin
      {bit_ff, byte_ff, rd_ff, adr_ok_ff, quiet_ff, lastack_ff, sh_ff} <= '0;
    end else if (rise) begin
      bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      if (bit_ff != 4'h8) sh_ff <= {sh_ff[6:0], sda};
      if (bit_ff == 4'h7 && byte_ff == 2'h0) rd_ff <= sda;
      if (bit_ff == 4'h8 && byte_ff == 2'h0) adr_ok_ff <= ~sda;
      if (bit_ff == 4'h8) begin
        byte_ff <= (byte_ff == 2'h3) ? 2'h3 : byte_ff + 2'h1;
        lastack_ff <= byte_ff == 2'h3 && !rd_ff && !sda;
        quiet_ff <= quiet_ff | (byte_ff != 2'h0 && rd_ff && sda);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_ff <= 0;
    else if (stop && lastack_ff && bit_ff == 4'h1) busy_cnt_ff <= WC_CYCLES;
    else if (busy_cnt_ff != 0) busy_cnt_ff <= busy_cnt_ff - 1;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  oe_stable_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("slave line moved while clock high");
  pre_start_a: assert property (!seen_ff |-> !sda_d_oe)
    else $error("slave drove before any start");
  addr_match_a: assert property (
    rise && bit_ff == 4'h8 && byte_ff == 2'h0 && !sda |-> sh_ff[7:1] == 7'h6f)
    else $error("ack given to foreign address");
  rx_release_a: assert property (
    rise && bit_ff < 4'h8 && (byte_ff == 2'h0 || !rd_ff) |-> !sda_d_oe)
    else $error("slave drove while receiving");
  ack_slot_a: assert property (rise && bit_ff == 4'h8 && byte_ff != 2'h0 && rd_ff
    |-> !sda_d_oe)
    else $error("slave held line in master ack slot");
  nack_quiet_a: assert property (quiet_ff |-> !sda_d_oe)
    else $error("slave sent after master nack");
  busy_quiet_a: assert property (busy_cnt_ff != 0 |-> !sda_d_oe)
    else $error("slave answered during write cycle");
  addr_ack_a: assert property (
    rise && bit_ff == 4'h8 && byte_ff inside {2'h1, 2'h2}
    && !rd_ff && adr_ok_ff |-> sda_d_oe)
    else $error("register address byte not acked");
endmodule : rsa_asserts
`default_nettype wire

// ===== test/rsa_tb.sv
// Bench joining host and register slave ends over the link
`timescale 1ns/100ps
`default_nettype none
module rsa_tb;
  import rsa_pkg::*;
  localparam int unsigned WC = 2000;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [3:0] n;
  } rsa_row_s;
  logic ref_clk, rst_n, write_enable_latch, cmd_valid, cmd_nack;
  logic cmd_ready_ff, rsp_valid_ff, rsp_ack_ff, busy_ff;
  rsa_op_e cmd_op;
  logic [7:0] cmd_wdata, rsp_rdata_ff, user_data_ff;
  logic [5:0] user_addr;
  logic [7:0] mem [64];
  logic [7:0] bad [5];
  rsa_row_s rows [3];
  int num_errors, n_checks;
  rsa_if i_rsa_if ();
  rsa_dev #(.REG_WORDS(64), .WC_CYCLES(WC)) i_rsa_dev (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(i_rsa_if.dev), .write_enable_latch(write_enable_latch), .user_addr(user_addr),
    .user_data_ff(user_data_ff), .busy_ff(busy_ff));
  rsa_host i_rsa_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(i_rsa_if.host),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .cmd_nack(cmd_nack),
    .cmd_ready_ff(cmd_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff),
    .rsp_ack_ff(rsp_ack_ff));
  rsa_asserts #(.WC_CYCLES(WC)) i_rsa_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl(i_rsa_if.scl), .sda(i_rsa_if.sda), .sda_d_oe(i_rsa_if.sda_d_oe));
  always #10 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang();
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    results();
  endtask : hang
  // Entered just after an edge; the host takes the command at the next one
  task automatic cmd(input rsa_op_e op, input logic [7:0] d, input logic nk);
    int k;
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_wdata <= d;
    cmd_nack <= nk;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp_valid_ff !== 1'h1 && k < 2000);
    if (k >= 2000) hang();
  endtask : cmd
  task automatic wb(input logic [7:0] d, input logic ea);
    cmd(OP_WRITE, d, 1'h0);
    chk({7'h00, rsp_ack_ff}, {7'h00, ea});
  endtask : wb
  task automatic setaddr(input logic [5:0] a);
    cmd(OP_START, 8'h00, 1'h0);
    wb(8'hde, 1'h1);
    wb(8'h00, 1'h1);
    wb({2'h0, a}, 1'h1);
  endtask : setaddr
  task automatic rdfrom(input logic set, input logic [5:0] a, input int n);
    logic [5:0] p;
    p = a;
    if (set) setaddr(a);
    cmd(OP_START, 8'h00, 1'h0);
    wb(8'hdf, 1'h1);
    for (int i = 0; i < n; i++) begin
      cmd(OP_READ, 8'h00, i == n - 1);
      chk(rsp_rdata_ff, mem[p]);
      p++;
    end
    cmd(OP_STOP, 8'h00, 1'h0);
  endtask : rdfrom
  // Poll lands long before the write cycle ends, so it must go unacked
  task automatic commit();
    int k;
    cmd(OP_STOP, 8'h00, 1'h0);
    cmd(OP_START, 8'h00, 1'h0);
    wb(8'hde, 1'h0);
    chk({7'h00, busy_ff}, 8'h01);
    cmd(OP_STOP, 8'h00, 1'h0);
    for (k = 0; busy_ff !== 1'h0 && k < 3000; k++) @(posedge ref_clk);
    if (k >= 3000) hang();
  endtask : commit
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rows = '{'{6'h00, 8'h11, 4'h1}, '{6'h0d, 8'h40, 4'h5}, '{6'h12, 8'h80, 4'ha}};
    bad = '{8'h5e, 8'h9e, 8'hd6, 8'hda, 8'hdb};
    foreach (mem[i]) mem[i] = 8'h00;
    ref_clk = 1'h0;
    rst_n = 1'h0;
    write_enable_latch = 1'h1;
    cmd_valid = 1'h0;
    cmd_op = OP_START;
    cmd_wdata = 8'h00;
    cmd_nack = 1'h0;
    user_addr = 6'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    chk({5'h00, busy_ff, cmd_ready_ff, i_rsa_if.sda}, 8'h03);
    $display("reset done");
    foreach (rows[r]) begin
      setaddr(rows[r].a);
      for (int i = 0; i < rows[r].n; i++) begin
        wb(rows[r].d + 8'(i), 1'h1);
        mem[{rows[r].a[5:3], rows[r].a[2:0] + 3'(i)}] = rows[r].d + 8'(i);
      end
      commit();
      rdfrom(1'h1, {rows[r].a[5:3], 3'h0}, 8);
      $display("row %0d done", r);
    end
    foreach (bad[i]) begin
      cmd(OP_START, 8'h00, 1'h0);
      wb(bad[i], 1'h0);
      cmd(OP_STOP, 8'h00, 1'h0);
    end
    $display("foreign address done");
    write_enable_latch <= 1'h0;
    setaddr(6'h21);
    wb(8'h55, 1'h0);
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (20) @(posedge ref_clk);
    chk({7'h00, busy_ff}, 8'h00);
    write_enable_latch <= 1'h1;
    rdfrom(1'h0, 6'h21, 1);
    rdfrom(1'h0, 6'h22, 1);
    setaddr(6'h30);
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (20) @(posedge ref_clk);
    chk({7'h00, busy_ff}, 8'h00);
    rdfrom(1'h1, 6'h3f, 3);
    $display("refused and wrap cases done");
    for (int a = 0; a < 64; a++) begin
      user_addr <= 6'(a);
      repeat (2) @(posedge ref_clk);
      chk(user_data_ff, mem[a]);
    end
    $display("store sweep done");
    // Mid-run reset must clear the store and accept a transfer at once
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(posedge ref_clk);
    chk({5'h00, busy_ff, cmd_ready_ff, i_rsa_if.sda}, 8'h03);
    rdfrom(1'h1, 6'h12, 2);
    $display("mid-run reset done");
    results();
  end
endmodule : rsa_tb
`default_nettype wire
